// [hw/memory_map_defs.vh]
`ifndef MEMORY_MAP_DEFS_VH
`define MEMORY_MAP_DEFS_VH

// Processor address map.
`define IO_BASE          16'h0000
`define IO_LAST          16'h003F
`define GAP0_BASE        16'h0040
`define GAP0_LAST        16'h007F
`define RAM_BASE         16'h0080
`define RAM_LAST         16'h00FF
`define RAM_BYTES        128
`define FLASH_BASE       16'h7800
`define FLASH_LAST       16'h7FEE
`define FLASH_BYTES      2031
`define TRIM_ADDR        16'h7FEF
`define MON_BASE         16'hF000
`define MON_LAST         16'hF2EF
`define MON_VEC_BASE     16'hFEF0
`define MON_VEC_LAST     16'hFEFF
`define MON_BYTES        768
`define BREAK_STATUS     16'hFE00
`define RESET_SRC_STATUS 16'hFE01
`define BREAK_FLAG_CTL   16'hFE02
`define RSVD_SIM_BASE    16'hFE03
`define RSVD_SIM_LAST    16'hFE06
`define FLASH_CONTROL    16'hFE08
`define RSVD_FLASH       16'hFE09
`define BRK_ADDR_HIGH    16'hFE0C
`define BRK_ADDR_LOW     16'hFE0D
`define BRK_STAT_CTL     16'hFE0E
`define LOW_VOLT_STATUS  16'hFE0F
`define FLASH_PROTECT    16'hFFF0
`define VEC_BASE         16'hFFF2
`define VEC_CLOCK_GEN    16'hFFF2
`define VEC_TIMER_OVF    16'hFFF4
`define VEC_TIMER_CH1    16'hFFF6
`define VEC_TIMER_CH0    16'hFFF8
`define VEC_EXT_KBD      16'hFFFA
`define VEC_SOFTWARE     16'hFFFC
`define VEC_RESET        16'hFFFE
`define WATCHDOG_CTL     16'hFFFF

// Stack usage figures.
`define STACK_INT_BYTES  3'd5
`define STACK_CALL_BYTES 3'd2

// Region codes.
`define RG_NONE          4'h0
`define RG_IO            4'h1
`define RG_RAM           4'h2
`define RG_FLASH         4'h3
`define RG_TRIM          4'h4
`define RG_MON           4'h5
`define RG_MON_VEC       4'h6
`define RG_HIGH_REG      4'h7
`define RG_VECTOR        4'h8
`define RG_RESERVED      4'h9

// AXI4-Lite register byte offsets.
`define A_STATUS         8'h00
`define A_MASK           8'h04
`define A_CONTROL        8'h08
`define A_LAST_ILLEGAL   8'h0C
`define A_LAST_SELECT    8'h10
`define A_INT_VECTOR     8'h14
`define A_STACK          8'h18
`define A_COUNT          8'h1C

// Status bits.
`define ST_ILLEGAL       0
`define ST_RESERVED      1
`define ST_STACK_OUT     2
`define ST_WIDTH         3

// Control bits.
`define CTL_RESET_EN     0

`define AXI_OKAY         2'b00
`define AXI_SLVERR       2'b10

`endif

// [hw/region_match.v]
`timescale 1ns/10ps
`default_nettype none

// One address window compare; instantiated for the I/O, RAM, flash, monitor, monitor vector and vector windows.
module region_match #(
    parameter [15:0] BASE = 16'h0000,
    parameter [15:0] LAST = 16'h0000
) (
    input  wire [15:0] addr,
    output wire        hit
);
    assign hit = (addr >= BASE) && (addr <= LAST);
endmodule

`default_nettype wire

// [hw/memory_map_decoder.v]
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_defs.vh"

// Behaviour
// - Unimplemented addresses, including the I/O-to-RAM gap, raise illegal-address reset.
// - Addresses from map bottom to end of I/O page select peripheral registers.
// - 128-byte RAM window follows the gap above the I/O page.
// - 2031 bytes of user flash; span between RAM and flash is unimplemented.
// - Byte after user flash decodes as reserved oscillator trim location.
// - Monitor ROM is 768 bytes: main code block plus 16-byte high block.
// - High 16-byte monitor block supplies monitor reset vectors.
// - First three high-page addresses select break, reset-source, break-flag registers.
// - Flash control, breakpoint high/low, break control, low-voltage registers decode fixed.
// - Flash protect at vector page start; watchdog shares last map address.
// - Two-byte vectors, high byte even, clock generator up to reset.
// - Priority rises with vector address; reset highest, clock generator lowest.
// - Interrupt entry pushes exactly five context bytes.
// - Interrupt stacking omits the upper index byte.
// - Subroutine call pushes a two-byte return address.
// - Stack pointer decrements on push and increments on pull.
module memory_map_decoder (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [15:0] bus_addr,
    input  wire        bus_valid,
    input  wire        bus_write,
    input  wire [6:0]  irq_pending,
    input  wire        stack_push,
    input  wire        stack_pull,
    input  wire        stack_int_entry,
    input  wire        stack_call,
    input  wire [15:0] stack_load_value,
    input  wire        stack_load,
    output reg  [3:0]  region_q,
    output reg  [15:0] select_q,
    output reg         illegal_reset_q,
    output reg  [15:0] vector_addr_q,
    output reg  [2:0]  vector_index_q,
    output reg  [15:0] stack_ptr_q,
    output reg  [2:0]  stack_bytes_q,
    output reg         irq_q,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    wire hit_io;
    wire hit_ram;
    wire hit_flash;
    wire hit_mon;
    wire hit_mon_vec;
    wire hit_vec;

    region_match #(.BASE(`IO_BASE), .LAST(`IO_LAST)) u_io (
        .addr (bus_addr),
        .hit  (hit_io)
    );
    region_match #(.BASE(`RAM_BASE), .LAST(`RAM_LAST)) u_ram (
        .addr (bus_addr),
        .hit  (hit_ram)
    );
    region_match #(.BASE(`FLASH_BASE), .LAST(`FLASH_LAST)) u_flash (
        .addr (bus_addr),
        .hit  (hit_flash)
    );
    region_match #(.BASE(`MON_BASE), .LAST(`MON_LAST)) u_mon (
        .addr (bus_addr),
        .hit  (hit_mon)
    );
    region_match #(.BASE(`MON_VEC_BASE), .LAST(`MON_VEC_LAST)) u_monv (
        .addr (bus_addr),
        .hit  (hit_mon_vec)
    );
    region_match #(.BASE(`VEC_BASE), .LAST(`WATCHDOG_CTL)) u_vec (
        .addr (bus_addr),
        .hit  (hit_vec)
    );

    // One-hot select of the high-page registers; bit order as listed.
    reg [15:0] sel_d;
    reg [3:0]  region_d;
    reg        reserved_d;
    always @* begin
        sel_d      = 16'h0000;
        region_d   = `RG_NONE;
        reserved_d = 1'b0;
        if (hit_io) begin
            region_d = `RG_IO;
        end else if (hit_ram) begin
            region_d = `RG_RAM;
        end else if (hit_flash) begin
            region_d = `RG_FLASH;
        end else if (bus_addr == `TRIM_ADDR) begin
            region_d = `RG_TRIM;
        end else if (hit_mon) begin
            region_d = `RG_MON;
        end else if (hit_mon_vec) begin
            region_d = `RG_MON_VEC;
        end else if (hit_vec) begin
            region_d = `RG_VECTOR;
            if (bus_addr == `WATCHDOG_CTL) begin
                sel_d[9] = 1'b1;
            end
        end else begin
            case (bus_addr)
                `BREAK_STATUS:     sel_d[0] = 1'b1;
                `RESET_SRC_STATUS: sel_d[1] = 1'b1;
                `BREAK_FLAG_CTL:   sel_d[2] = 1'b1;
                `FLASH_CONTROL:    sel_d[3] = 1'b1;
                `BRK_ADDR_HIGH:    sel_d[4] = 1'b1;
                `BRK_ADDR_LOW:     sel_d[5] = 1'b1;
                `BRK_STAT_CTL:     sel_d[6] = 1'b1;
                `LOW_VOLT_STATUS:  sel_d[7] = 1'b1;
                `FLASH_PROTECT:    sel_d[8] = 1'b1;
                default:           sel_d    = 16'h0000;
            endcase
            if (sel_d != 16'h0000) begin
                region_d = `RG_HIGH_REG;
            end
            // Reserved bytes are decoded but not trapped; software avoids them.
            if ((bus_addr >= `RSVD_SIM_BASE && bus_addr <= `RSVD_SIM_LAST) ||
                bus_addr == `RSVD_FLASH) begin
                region_d   = `RG_RESERVED;
                reserved_d = 1'b1;
            end
        end
    end

    // Combinational flag; the registered copy below lands next edge.
    wire illegal_now = bus_valid && (region_d == `RG_NONE);

    // Vector selection: the highest pending request wins.
    reg [2:0] vidx_d;
    integer   i;
    always @* begin
        vidx_d = 3'd0;
        for (i = 0; i < 7; i = i + 1) begin
            if (irq_pending[i]) begin
                vidx_d = i[2:0];
            end
        end
    end
    wire [15:0] vaddr_d = `VEC_BASE + {12'h000, vidx_d, 1'b0};

    // Stack pointer model.
    wire stack_out = (stack_ptr_q < `RAM_BASE) || (stack_ptr_q > `RAM_LAST);

    reg [2:0] st_status_q;
    reg [2:0] st_mask_q;
    reg       ctl_q;
    reg [15:0] last_illegal_q;
    reg [15:0] illegal_count_q;

    wire [2:0] st_event = {stack_out, reserved_d && bus_valid, illegal_now};

    always @(posedge aclk) begin
        if (!aresetn) begin
            region_q        <= `RG_NONE;
            select_q        <= 16'h0000;
            illegal_reset_q <= 1'b0;
            vector_addr_q   <= `VEC_RESET;
            vector_index_q  <= 3'd6;
            stack_ptr_q     <= `RAM_LAST;
            stack_bytes_q   <= 3'd0;
            last_illegal_q  <= 16'h0000;
            illegal_count_q <= 16'h0000;
        end else begin
            region_q        <= bus_valid ? region_d : `RG_NONE;
            select_q        <= bus_valid ? sel_d : 16'h0000;
            illegal_reset_q <= illegal_now && ctl_q;
            vector_addr_q   <= vaddr_d;
            vector_index_q  <= vidx_d;
            if (illegal_now) begin
                last_illegal_q  <= bus_addr;
                illegal_count_q <= illegal_count_q + 16'h0001;
            end
            if (stack_load) begin
                stack_ptr_q <= stack_load_value;
            end else if (stack_int_entry) begin
                // Index high byte is not stacked, so five bytes only.
                stack_ptr_q   <= stack_ptr_q - {13'h0000, `STACK_INT_BYTES};
                stack_bytes_q <= `STACK_INT_BYTES;
            end else if (stack_call) begin
                stack_ptr_q   <= stack_ptr_q - {13'h0000, `STACK_CALL_BYTES};
                stack_bytes_q <= `STACK_CALL_BYTES;
            end else if (stack_push) begin
                stack_ptr_q <= stack_ptr_q - 16'h0001;
            end else if (stack_pull) begin
                stack_ptr_q <= stack_ptr_q + 16'h0001;
            end
        end
    end

    // AXI4-Lite slave: one write and one read at a time.
    reg       aw_hold_q;
    reg       w_hold_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire      wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire      rd_go = s_axi_arvalid && s_axi_arready;
    wire      rd_status = rd_go && (s_axi_araddr == `A_STATUS);

    reg [31:0] rd_d;
    reg        rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `A_STATUS:       rd_d = {29'h0, st_status_q};
            `A_MASK:         rd_d = {29'h0, st_mask_q};
            `A_CONTROL:      rd_d = {31'h0, ctl_q};
            `A_LAST_ILLEGAL: rd_d = {16'h0, last_illegal_q};
            `A_LAST_SELECT:  rd_d = {12'h0, region_q, select_q};
            `A_INT_VECTOR:   rd_d = {13'h0, vector_index_q, vector_addr_q};
            `A_STACK:        rd_d = {13'h0, stack_bytes_q, stack_ptr_q};
            `A_COUNT:        rd_d = {16'h0, illegal_count_q};
            default: begin
                rd_d  = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `AXI_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            st_status_q   <= 3'b000;
            st_mask_q     <= 3'b000;
            ctl_q         <= 1'b1;
            irq_q         <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `AXI_OKAY;
                if (aw_addr_q == `A_MASK) begin
                    if (w_strb_q[0]) begin
                        st_mask_q <= w_data_q[2:0];
                    end
                end else if (aw_addr_q == `A_CONTROL) begin
                    if (w_strb_q[0]) begin
                        ctl_q <= w_data_q[`CTL_RESET_EN];
                    end
                end else if (aw_addr_q != `A_STATUS &&
                             aw_addr_q != `A_LAST_ILLEGAL &&
                             aw_addr_q != `A_LAST_SELECT &&
                             aw_addr_q != `A_INT_VECTOR &&
                             aw_addr_q != `A_STACK &&
                             aw_addr_q != `A_COUNT) begin
                    s_axi_bresp <= `AXI_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_d;
                s_axi_rresp  <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // A new event in the read cycle survives the clear.
            st_status_q <= (rd_status ? 3'b000 : st_status_q) | st_event;
            irq_q <= |(((rd_status ? 3'b000 : st_status_q) | st_event) &
                       st_mask_q);
        end
    end

endmodule

`default_nettype wire

// [dv/memory_map_decoder_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_defs.vh"
module memory_map_decoder_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_valid,
    input wire logic [6:0]  irq_pending,
    input wire logic        stack_push,
    input wire logic        stack_int_entry,
    input wire logic        stack_call,
    input wire logic        stack_load,
    input wire logic [3:0]  region_q,
    input wire logic [15:0] select_q,
    input wire logic        illegal_reset_q,
    input wire logic [15:0] vector_addr_q,
    input wire logic [2:0]  vector_index_q,
    input wire logic [15:0] stack_ptr_q,
    input wire logic [2:0]  stack_bytes_q,
    input wire logic        irq_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    function automatic logic [2:0] top_bit(input logic [6:0] p);
        top_bit = 3'd0;
        for (int i = 0; i < 7; i++)
            if (p[i])
                top_bit = 3'(i);
    endfunction
    property p_reg(lo, hi, rg);
        bus_valid && bus_addr >= lo && bus_addr <= hi |=> region_q == rg;
    endproperty
    property p_sel(a, s);
        bus_valid && bus_addr == a |=> select_q == s;
    endproperty
    a_gap_none: assert property (p_reg(`GAP0_BASE, `GAP0_LAST, `RG_NONE))
        else $error("gap not unimplemented");
    a_io_region: assert property (p_reg(`IO_BASE, `IO_LAST, `RG_IO))
        else $error("io region wrong");
    a_ram_region: assert property (p_reg(`RAM_BASE, `RAM_LAST, `RG_RAM))
        else $error("ram region wrong");
    a_flash_region: assert property (p_reg(16'h7800, 16'h7FEE, 4'h3))
        else $error("flash region wrong");
    a_trim_byte: assert property (p_reg(16'h7FEF, 16'h7FEF, 4'h4))
        else $error("trim byte wrong");
    a_mon_region: assert property (p_reg(16'hF000, 16'hF2EF, 4'h5))
        else $error("monitor region wrong");
    a_mon_vectors: assert property (p_reg(16'hFEF0, 16'hFEFF, 4'h6))
        else $error("monitor vector block wrong");
    a_break_sel: assert property (p_sel(16'hFE02, 16'h0004))
        else $error("break flag select wrong");
    a_watchdog_sel: assert property (p_sel(16'hFFFF, 16'h0200))
        else $error("watchdog select wrong");
    a_illegal_cause: assert property (
        illegal_reset_q |-> $past(bus_valid) && region_q == `RG_NONE)
        else $error("illegal reset without cause");
    a_vector_pair: assert property (
        vector_addr_q == 16'hFFF2 + {12'h000, vector_index_q, 1'b0})
        else $error("vector address not paired with index");
    a_vector_prio: assert property (
        irq_pending != 7'h00 |=> vector_index_q == top_bit($past(irq_pending)))
        else $error("vector priority wrong");
    a_int_stack: assert property (
        stack_int_entry && !stack_load |=> stack_bytes_q == 3'd5
        && stack_ptr_q == $past(stack_ptr_q) - 16'd5)
        else $error("interrupt stacking wrong");
    a_call_stack: assert property (
        stack_call && !stack_load && !stack_int_entry |=>
        stack_bytes_q == 3'd2 && stack_ptr_q == $past(stack_ptr_q) - 16'd2)
        else $error("call stacking wrong");
    a_push_dec: assert property (
        stack_push && !stack_load && !stack_int_entry && !stack_call |=>
        stack_ptr_q == $past(stack_ptr_q) - 16'd1)
        else $error("push did not decrement");
    c_illegal: cover property (illegal_reset_q);
    c_int_entry: cover property (stack_int_entry);
    c_irq_rise: cover property ($rose(irq_q));
endmodule
bind memory_map_decoder memory_map_decoder_monitor u_monitor (
    .aclk, .aresetn, .bus_addr, .bus_valid, .irq_pending,
    .stack_push, .stack_int_entry, .stack_call, .stack_load,
    .region_q, .select_q, .illegal_reset_q, .vector_addr_q,
    .vector_index_q, .stack_ptr_q, .stack_bytes_q, .irq_q
);
`default_nettype wire

// [dv/cpu_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        req,
    input  wire logic [15:0] req_addr,
    output var  logic [15:0] bus_addr = 16'h0000,
    output var  logic        bus_valid = 1'b0,
    output var  logic        bus_write = 1'b0
);
    // Reserved places and stack moves out of RAM occur only on request.
    always @(posedge aclk) begin
        bus_write <= 1'b0;
        bus_valid <= aresetn && req;
        // An idle address flips so a stale value never passes for a new one.
        bus_addr <= (aresetn && req) ? req_addr : ~bus_addr;
    end
endmodule
`default_nettype wire

// [dv/memory_map_decoder_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_defs.vh"
module memory_map_decoder_tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, req = 1'b0;
    logic [15:0] req_addr = 16'h0000, bus_addr, stack_load_value = 16'h0000;
    logic        bus_valid, bus_write, stack_push = 1'b0, stack_pull = 1'b0;
    logic        stack_int_entry = 1'b0, stack_call = 1'b0, stack_load = 1'b0;
    logic [6:0]  irq_pending = 7'h00;
    logic [3:0]  region_q;
    logic [15:0] select_q, vector_addr_q, stack_ptr_q;
    logic        illegal_reset_q, irq_q;
    logic [2:0]  vector_index_q, stack_bytes_q;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, n_compared = 0;
    logic [35:0] tbl [0:31] = '{
        36'h0000_1_0000, 36'h003F_1_0000, 36'h0040_0_0000, 36'h007F_0_0000,
        36'h0080_2_0000, 36'h00FF_2_0000, 36'h0100_0_0000, 36'h77FF_0_0000,
        36'h7800_3_0000, 36'h7FEE_3_0000, 36'h7FEF_4_0000, 36'h7FF0_0_0000,
        36'hF000_5_0000, 36'hF2EF_5_0000, 36'hF2F0_0_0000, 36'hFE00_7_0001,
        36'hFE01_7_0002, 36'hFE02_7_0004, 36'hFE03_9_0000, 36'hFE06_9_0000,
        36'hFE07_0_0000, 36'hFE08_7_0008, 36'hFE09_9_0000, 36'hFE0C_7_0010,
        36'hFE0D_7_0020, 36'hFE0E_7_0040, 36'hFE0F_7_0080, 36'hFEF0_6_0000,
        36'hFEFF_6_0000, 36'hFFF0_F_0100, 36'hFFF2_8_0000, 36'hFFFF_8_0200};

    cpu_bus_model core (.aclk, .aresetn, .req, .req_addr, .bus_addr,
        .bus_valid, .bus_write);
    memory_map_decoder dut (.aclk, .aresetn, .bus_addr, .bus_valid,
        .bus_write, .irq_pending, .stack_push, .stack_pull, .stack_int_entry,
        .stack_call, .stack_load_value, .stack_load, .region_q, .select_q,
        .illegal_reset_q, .vector_addr_q, .vector_index_q, .stack_ptr_q,
        .stack_bytes_q, .irq_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    initial begin
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] rsp);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk("write response", rsp, s_axi_bresp);
        if (n == 50) begin
            err_total++;
            close_out();
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] rsp);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk("read response", rsp, s_axi_rresp);
        chk("read data", d, s_axi_rdata);
        if (n == 50) begin
            err_total++;
            close_out();
        end
    endtask
    // One processor access; a region of F is not compared.
    task automatic acc(input logic [15:0] a, input logic [3:0] rg,
                       input logic [15:0] sel, input logic ill);
        @(posedge aclk);
        req <= 1'b1;
        req_addr <= a;
        @(posedge aclk);
        req <= 1'b0;
        @(posedge aclk);
        #1;
        if (rg !== 4'hF)
            chk("region", rg, region_q);
        chk("select", sel, select_q);
        chk("illegal reset", ill, illegal_reset_q);
    endtask
    // Operation bits are load, interrupt entry, call, push, pull.
    task automatic st(input logic [4:0] op, input logic [15:0] v, sp,
                      input logic [2:0] nb);
        @(posedge aclk);
        {stack_load, stack_int_entry, stack_call, stack_push, stack_pull} <= op;
        stack_load_value <= v;
        @(posedge aclk);
        {stack_load, stack_int_entry, stack_call, stack_push, stack_pull}
            <= 5'b00000;
        #1;
        chk("stack pointer", sp, stack_ptr_q);
        if (nb != 3'd0)
            chk("stacked bytes", nb, stack_bytes_q);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk("reset vector", 16'hFFFE, vector_addr_q);
        chk("reset stack", 16'h00FF, stack_ptr_q);
        st(5'b01000, 16'h0, 16'h00FA, 3'd5);
        st(5'b00100, 16'h0, 16'h00F8, 3'd2);
        st(5'b00010, 16'h0, 16'h00F7, 3'd0);
        st(5'b00001, 16'h0, 16'h00F8, 3'd0);
        st(5'b01011, 16'h0, 16'h00F3, 3'd5);
        st(5'b11111, 16'h00C0, 16'h00C0, 3'd0);
        st(5'b10000, 16'h0080, 16'h0080, 3'd0);
        st(5'b00001, 16'h0, 16'h0081, 3'd0);
        for (int i = 0; i < 7; i++) begin
            @(posedge aclk);
            irq_pending <= 7'h01 | (7'h01 << i);
            repeat (2) @(posedge aclk);
            #1;
            chk("vector index", i, vector_index_q);
            chk("vector address", 16'hFFF2 + 2 * i, vector_addr_q);
        end
        irq_pending <= 7'h00;
        foreach (tbl[i])
            acc(tbl[i][35:20], tbl[i][19:16], tbl[i][15:0],
                tbl[i][19:16] == 4'h0);
        @(posedge aclk);
        #1;
        chk("irq while masked", 1'b0, irq_q);
        axi_rd(`A_STATUS, 32'h3, `AXI_OKAY);
        axi_rd(`A_STATUS, 32'h0, `AXI_OKAY);
        axi_rd(`A_COUNT, 32'h7, `AXI_OKAY);
        axi_rd(`A_LAST_ILLEGAL, 32'hFE07, `AXI_OKAY);
        axi_wr(`A_MASK, 32'h1, `AXI_OKAY);
        acc(16'h0100, 4'h0, 16'h0000, 1'b1);
        repeat (3) @(posedge aclk);
        #1;
        chk("irq raised", 1'b1, irq_q);
        @(posedge aclk);
        axi_rd(`A_STATUS, 32'h1, `AXI_OKAY);
        repeat (3) @(posedge aclk);
        #1;
        chk("irq cleared", 1'b0, irq_q);
        @(posedge aclk);
        axi_wr(`A_CONTROL, 32'h0, `AXI_OKAY);
        acc(16'h0040, 4'h0, 16'h0000, 1'b0);
        @(posedge aclk);
        axi_rd(8'h20, 32'h0, `AXI_SLVERR);
        axi_wr(8'h20, 32'h1, `AXI_SLVERR);
        axi_wr(`A_STATUS, 32'h0, `AXI_OKAY);
        st(5'b10000, 16'h0100, 16'h0100, 3'd0);
        axi_rd(`A_STATUS, 32'h5, `AXI_OKAY);
        close_out();
    end
endmodule
`default_nettype wire
